/* File: src/mlic_ctrl.sv */
// Multi-level interrupt controller: arbitration, nesting and vector delivery.
//
// Summary of operation
// [R1] Three levels; each source picks one.
// [R2] Medium may preempt a running low routine.
// [R3] High may preempt low and medium routines.
// [R4] Low level: fixed or round-robin, software-selected.
// [R5] Round-robin rotates so no low source starves.
// [R6] Oscillator failure raises a level-independent NMI.
// [R7] Each interrupt source has its own vector.
// [R8] Serviced vector is loaded into program counter.
// [R9] Vector equals peripheral base plus interrupt offset.
// [R10] Vectors are program-memory word addresses.
// [R11] Whole table relocatable to boot section start.
// [R12] Reset vector at zero, relocatable to boot.
// [R13] Oscillator-failure NMI vectors to word two.
// [R14] Port C, aux port, DMA bases fixed.
// [R15] Timer C four, C two, E four bases.
// [R16] Single-interrupt units use listed address directly.
// [R17] Counter, memory controller, converter bases fixed.
// [R18] Order: NMI, then high, medium, low.
// [R19] Same or lower level waits until return.
`timescale 1ns/100ps
module mlic_ctrl
	import mlic_pkg::*;
(
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// Peripheral requests
	input wire logic [SRC_N-1:0] irq_req,
	input wire logic [SRC_N-1:0][LVL_W-1:0] irq_level,
	input wire logic [SRC_N-1:0][OFS_W-1:0] irq_offset,
	input wire logic osc_fail,
	// Control settings
	input wire logic global_irq_en,
	input wire logic high_en,
	input wire logic med_en,
	input wire logic low_en,
	input wire logic low_round_robin,
	input wire logic vectors_in_boot,
	input wire logic reset_vec_in_boot,
	// Processor core side
	input wire logic core_vec_ack,
	input wire logic core_reti,
	output logic pc_load,
	output logic [ADDR_W-1:0] pc_vector,
	output logic [SRC_N-1:0] src_taken,
	output logic nmi_taken,
	output logic [ACT_W-1:0] active_levels
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	mlic_state_t state_reg;
	mlic_state_t state_next;
	logic pc_load_reg;
	logic pc_load_next;
	logic [ADDR_W-1:0] pc_vector_reg;
	logic [ADDR_W-1:0] pc_vector_next;
	logic [SRC_N-1:0] src_taken_reg;
	logic [SRC_N-1:0] src_taken_next;
	logic nmi_taken_reg;
	logic nmi_taken_next;
	logic [ACT_W-1:0] act_reg;
	logic [ACT_W-1:0] act_next;
	logic [ACT_W-1:0] grant_lvl_reg;
	logic [ACT_W-1:0] grant_lvl_next;
	logic [SRC_N-1:0] grant_src_reg;
	logic [SRC_N-1:0] grant_src_next;
	logic nmi_pend_reg;
	logic nmi_pend_next;
	logic osc_fail_d_reg;
	logic [IDX_W-1:0] rr_last_reg;
	logic [IDX_W-1:0] rr_last_next;

	// ----------------------------------------------------------------
	// Level decode of the requests
	// ----------------------------------------------------------------
	logic [SRC_N-1:0] req_high;
	logic [SRC_N-1:0] req_med;
	logic [SRC_N-1:0] req_low;

	for (genvar g = 0; g < SRC_N; g++) begin : g_lvl
		assign req_high[g] = irq_req[g] && (irq_level[g] == LVL_HIGH); // [R1]
		assign req_med[g] = irq_req[g] && (irq_level[g] == LVL_MED); // [R1]
		assign req_low[g] = irq_req[g] && (irq_level[g] == LVL_LOW); // [R1]
	end

	// ----------------------------------------------------------------
	// One picker per level
	// ----------------------------------------------------------------
	mlic_pick_if pick_high ();
	mlic_pick_if pick_med ();
	mlic_pick_if pick_low ();

	// After the last served low source comes the next one, so each pending
	// low source waits at most SRC_N-1 low services.
	wire logic [IDX_W-1:0] rr_start = (rr_last_reg >= IDX_W'(SRC_N - 1)) ? '0 : rr_last_reg + 1'b1; // [R5]

	assign pick_high.req = req_high;
	assign pick_high.start = '0;
	assign pick_med.req = req_med;
	assign pick_med.start = '0;
	assign pick_low.req = req_low;
	assign pick_low.start = low_round_robin ? rr_start : '0; // [R4]

	mlic_pick u_pick_high (
		.p(pick_high)
	);
	mlic_pick u_pick_med (
		.p(pick_med)
	);
	mlic_pick u_pick_low (
		.p(pick_low)
	);

	// ----------------------------------------------------------------
	// Nesting: a level may enter only above every active level
	// ----------------------------------------------------------------
	wire logic above_med = !act_reg[ACT_NMI] && !act_reg[ACT_HIGH];
	wire logic above_low = above_med && !act_reg[ACT_MED];
	wire logic above_none = above_low && !act_reg[ACT_LOW];

	// The NMI ignores the enables and the active maskable levels.
	wire logic ok_nmi = nmi_pend_reg && !act_reg[ACT_NMI]; // [R6]
	wire logic ok_high = pick_high.found && global_irq_en && high_en && above_med; // [R3] [R19]
	wire logic ok_med = pick_med.found && global_irq_en && med_en && above_low; // [R2] [R19]
	wire logic ok_low = pick_low.found && global_irq_en && low_en && above_none; // [R19]
	wire logic any_ok = ok_nmi || ok_high || ok_med || ok_low;

	// ----------------------------------------------------------------
	// Winner selection and its vector
	// ----------------------------------------------------------------
	wire logic [IDX_W-1:0] win_idx = ok_high ? pick_high.idx : (ok_med ? pick_med.idx : pick_low.idx); // [R18]
	wire logic [ACT_W-1:0] win_lvl = ok_nmi ? ACT_W'(1 << ACT_NMI) :
		(ok_high ? ACT_W'(1 << ACT_HIGH) : (ok_med ? ACT_W'(1 << ACT_MED) : ACT_W'(1 << ACT_LOW))); // [R18]
	wire logic [SRC_N-1:0] win_src = ok_nmi ? '0 : SRC_N'(1) << win_idx; // [R7]
	wire logic [OFS_W-1:0] win_ofs = irq_offset[(win_idx < IDX_W'(SRC_N)) ? win_idx : '0];
	wire logic [ADDR_W-1:0] win_addr;

	mlic_vector u_vector (
		.idx(win_idx),
		.ofs(win_ofs),
		.is_nmi(ok_nmi),
		.in_boot(vectors_in_boot),
		.addr(win_addr)
	);

	wire logic [ADDR_W-1:0] reset_addr = reset_vec_in_boot ? BOOT_SECTION_START : RESET_VECTOR; // [R12]

	// ----------------------------------------------------------------
	// Return handling: the highest active level finishes first
	// ----------------------------------------------------------------
	wire logic [ACT_W-1:0] ret_clear = act_reg[ACT_NMI] ? ACT_W'(1 << ACT_NMI) :
		(act_reg[ACT_HIGH] ? ACT_W'(1 << ACT_HIGH) :
		(act_reg[ACT_MED] ? ACT_W'(1 << ACT_MED) : ACT_W'(act_reg[ACT_LOW])));
	wire logic taking = (state_reg == ST_PRESENT) && core_vec_ack;
	wire logic taking_nmi = taking && grant_lvl_reg[ACT_NMI];
	wire logic osc_rise = osc_fail && !osc_fail_d_reg;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		pc_load_next = pc_load_reg;
		pc_vector_next = pc_vector_reg;
		grant_lvl_next = grant_lvl_reg;
		grant_src_next = grant_src_reg;
		src_taken_next = '0;
		nmi_taken_next = 1'b0;
		case (state_reg)
			ST_RESET: begin
				pc_load_next = 1'b1; // [R12]
				pc_vector_next = reset_addr;
				grant_lvl_next = '0;
				grant_src_next = '0;
				state_next = ST_PRESENT;
			end
			ST_IDLE: begin
				if (any_ok) begin
					pc_load_next = 1'b1; // [R8]
					pc_vector_next = win_addr; // [R8]
					grant_lvl_next = win_lvl;
					grant_src_next = win_src;
					state_next = ST_PRESENT;
				end
			end
			ST_PRESENT: begin
				if (core_vec_ack) begin
					pc_load_next = 1'b0;
					src_taken_next = grant_src_reg;
					nmi_taken_next = grant_lvl_reg[ACT_NMI];
					state_next = ST_IDLE;
				end
			end
			default: begin
				pc_load_next = 1'b0;
				state_next = ST_IDLE;
			end
		endcase
	end

	// A return in the same cycle as an acceptance retires the older level,
	// which is always below the new one.
	assign act_next = (act_reg & ~(core_reti ? ret_clear : '0)) | (taking ? grant_lvl_reg : '0);

	// The set wins over the clear if a new failure edge meets the service.
	assign nmi_pend_next = (nmi_pend_reg && !taking_nmi) || osc_rise; // [R6]

	assign rr_last_next = (taking && grant_lvl_reg[ACT_LOW] && low_round_robin) ? pc_rr_idx(grant_src_reg) : rr_last_reg; // [R5]

	function automatic logic [IDX_W-1:0] pc_rr_idx(input logic [SRC_N-1:0] onehot);
		logic [IDX_W-1:0] r;
		r = '0;
		for (int k = 0; k < SRC_N; k++) begin
			if (onehot[k]) begin
				r = IDX_W'(k);
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_RESET;
			pc_load_reg <= 1'b0;
			pc_vector_reg <= RESET_VECTOR;
			src_taken_reg <= '0;
			nmi_taken_reg <= 1'b0;
			grant_lvl_reg <= '0;
			grant_src_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			pc_load_reg <= pc_load_next;
			pc_vector_reg <= pc_vector_next;
			src_taken_reg <= src_taken_next;
			nmi_taken_reg <= nmi_taken_next;
			grant_lvl_reg <= grant_lvl_next;
			grant_src_reg <= grant_src_next;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			act_reg <= '0;
			nmi_pend_reg <= 1'b0;
			osc_fail_d_reg <= 1'b0;
			rr_last_reg <= IDX_W'(SRC_N - 1);
		end else if (ce) begin
			act_reg <= act_next; // [R2] [R3]
			nmi_pend_reg <= nmi_pend_next;
			osc_fail_d_reg <= osc_fail;
			rr_last_reg <= rr_last_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign pc_load = pc_load_reg;
	assign pc_vector = pc_vector_reg; // [R10]
	assign src_taken = src_taken_reg;
	assign nmi_taken = nmi_taken_reg;
	assign active_levels = act_reg;

	// ----------------------------------------------------------------
	// Source index map
	// ----------------------------------------------------------------
	// Base addresses in use, by source index, so that board-level wiring of
	// the request bits can be checked against the vector table.
	// Index 0: first general-purpose port group. [R14]
	// Index 1: auxiliary port group. [R14]
	// Index 2: direct-memory-access controller. [R14]
	// Index 3: real-time counter. [R17]
	// Index 4: four-channel timer on port group C. [R15]
	// Index 5: two-channel timer on port group C. [R15]
	// Index 6: serial-peripheral unit on port group C, single vector. [R16]
	// Index 7: cipher engine, single vector. [R16]
	// Index 8: non-volatile memory controller. [R17]
	// Index 9: converter on port group B. [R17]
	// Index 10: four-channel timer on port group E. [R15]
	// Index 11: serial-peripheral unit on port group E, single vector. [R16]
	// Offsets that run past the next base are the peripheral's concern; the
	// adder does not clip them, which keeps the vector path two plain adders deep.

endmodule // mlic_ctrl

/* File: src/mlic_pick.sv */
// Picker that finds the first pending request searching upward from a start index.
`timescale 1ns/100ps
module mlic_pick
	import mlic_pkg::*;
(
	// Request and answer
	mlic_pick_if.arb p
);

	always_comb begin
		int j;
		j = 0;
		p.found = 1'b0;
		p.idx = '0;
		for (int i = 0; i < SRC_N; i++) begin
			j = int'(p.start) + i;
			if (j >= SRC_N) begin
				j = j - SRC_N;
			end
			if (!p.found && p.req[j]) begin
				p.found = 1'b1;
				p.idx = IDX_W'(j);
			end
		end
	end

endmodule // mlic_pick

/* File: src/mlic_pick_if.sv */
// Interface joining the controller to one of its request pickers.
`timescale 1ns/100ps
interface mlic_pick_if;
	import mlic_pkg::*;
	logic [SRC_N-1:0] req;
	logic [IDX_W-1:0] start;
	logic found;
	logic [IDX_W-1:0] idx;

	modport arb (input req, input start, output found, output idx);
	modport user (output req, output start, input found, input idx);
endinterface

/* File: src/mlic_pkg.sv */
// Package of constants and types shared by the multi-level interrupt controller files.
package mlic_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int SRC_N = 12;
	localparam int IDX_W = 4;
	localparam int OFS_W = 4;
	localparam int ADDR_W = 16;
	localparam int LVL_W = 2;

	// ----------------------------------------------------------------
	// Priority level codes carried by each peripheral request
	// ----------------------------------------------------------------
	localparam logic [LVL_W-1:0] LVL_OFF = 2'h0;
	localparam logic [LVL_W-1:0] LVL_LOW = 2'h1;
	localparam logic [LVL_W-1:0] LVL_MED = 2'h2;
	localparam logic [LVL_W-1:0] LVL_HIGH = 2'h3;

	// ----------------------------------------------------------------
	// Active-level bit positions
	// ----------------------------------------------------------------
	localparam int ACT_LOW = 0;
	localparam int ACT_MED = 1;
	localparam int ACT_HIGH = 2;
	localparam int ACT_NMI = 3;
	localparam int ACT_W = 4;

	// ----------------------------------------------------------------
	// Word addresses of the vector table
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] RESET_VECTOR = 16'h0000;
	localparam logic [ADDR_W-1:0] OSC_FAILURE_NMI_VECTOR = 16'h0002;
	localparam logic [ADDR_W-1:0] PORT_GROUP_C_VECTOR_BASE = 16'h0004;
	localparam logic [ADDR_W-1:0] AUX_PORT_GROUP_VECTOR_BASE = 16'h0008;
	localparam logic [ADDR_W-1:0] DMA_CTRL_VECTOR_BASE = 16'h000C;
	localparam logic [ADDR_W-1:0] RT_COUNTER_VECTOR_BASE = 16'h0014;
	localparam logic [ADDR_W-1:0] TIMER_C_FOUR_CHAN_VECTOR_BASE = 16'h001C;
	localparam logic [ADDR_W-1:0] TIMER_C_TWO_CHAN_VECTOR_BASE = 16'h0028;
	localparam logic [ADDR_W-1:0] SERIAL_PERIPH_C_VECTOR = 16'h0030;
	localparam logic [ADDR_W-1:0] CIPHER_ENGINE_VECTOR = 16'h003E;
	localparam logic [ADDR_W-1:0] NONVOLATILE_CTRL_VECTOR_BASE = 16'h0040;
	localparam logic [ADDR_W-1:0] CONVERTER_B_VECTOR_BASE = 16'h004E;
	localparam logic [ADDR_W-1:0] TIMER_E_FOUR_CHAN_VECTOR_BASE = 16'h005E;
	localparam logic [ADDR_W-1:0] SERIAL_PERIPH_E_VECTOR = 16'h0072;
	// First word of the boot section; the value is a plain default.
	localparam logic [ADDR_W-1:0] BOOT_SECTION_START = 16'h8000;

	// Source index order: request bit i uses VECTOR_BASE[i].
	localparam logic [ADDR_W-1:0] VECTOR_BASE [SRC_N] = '{
		PORT_GROUP_C_VECTOR_BASE, AUX_PORT_GROUP_VECTOR_BASE, DMA_CTRL_VECTOR_BASE,
		RT_COUNTER_VECTOR_BASE, TIMER_C_FOUR_CHAN_VECTOR_BASE, TIMER_C_TWO_CHAN_VECTOR_BASE,
		SERIAL_PERIPH_C_VECTOR, CIPHER_ENGINE_VECTOR, NONVOLATILE_CTRL_VECTOR_BASE,
		CONVERTER_B_VECTOR_BASE, TIMER_E_FOUR_CHAN_VECTOR_BASE, SERIAL_PERIPH_E_VECTOR
	};
	// Sources with a single interrupt take their address as the whole vector.
	localparam logic [SRC_N-1:0] SINGLE_VECTOR_MASK = 12'h8C0;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RESET = 3'h1,
		ST_IDLE = 3'h2,
		ST_PRESENT = 3'h4
	} mlic_state_t;

endpackage

/* File: src/mlic_vector.sv */
// Vector address former: fixed base plus per-interrupt offset, with boot relocation.
`timescale 1ns/100ps
module mlic_vector
	import mlic_pkg::*;
(
	// Selection
	input wire logic [IDX_W-1:0] idx,
	input wire logic [OFS_W-1:0] ofs,
	input wire logic is_nmi,
	input wire logic in_boot,
	// Result
	output logic [ADDR_W-1:0] addr
);

	wire logic [IDX_W-1:0] safe_idx = (idx < IDX_W'(SRC_N)) ? idx : '0;
	wire logic [ADDR_W-1:0] base = VECTOR_BASE[safe_idx]; // [R14] [R15] [R17]
	wire logic [ADDR_W-1:0] ofs_ext = SINGLE_VECTOR_MASK[safe_idx] ? '0 : {{(ADDR_W-OFS_W){1'b0}}, ofs}; // [R16]
	wire logic [ADDR_W-1:0] local_addr = is_nmi ? OSC_FAILURE_NMI_VECTOR : base + ofs_ext; // [R9] [R13]
	wire logic [ADDR_W-1:0] table_start = in_boot ? BOOT_SECTION_START : RESET_VECTOR; // [R11]

	assign addr = table_start + local_addr; // [R10]

endmodule // mlic_vector

/* File: verif/mlic_core_model.sv */
// Behavioural core that takes each offered vector after a set number of cycles.
`timescale 1ns/100ps
module mlic_core_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Vector handshake
	input wire logic pc_load,
	input wire logic [7:0] ack_wait,
	output logic core_vec_ack
);
	logic [7:0] wait_reg;

	// The ack is a single pulse, so one vector is never taken twice.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wait_reg <= 8'h00;
			core_vec_ack <= 1'h0;
		end else if (pc_load && !core_vec_ack && wait_reg == ack_wait) begin
			wait_reg <= 8'h00;
			core_vec_ack <= 1'h1;
		end else begin
			wait_reg <= (pc_load && !core_vec_ack) ? wait_reg + 8'h01 : 8'h00;
			core_vec_ack <= 1'h0;
		end
	end
endmodule // mlic_core_model

/* File: verif/mlic_ctrl_assertions.sv */
// Checker of the controller's vector handshake, taking pulses and nesting.
`timescale 1ns/100ps
module mlic_ctrl_assertions
	import mlic_pkg::*;
(
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// Observed ports
	input wire logic vectors_in_boot,
	input wire logic core_vec_ack,
	input wire logic core_reti,
	input wire logic pc_load,
	input wire logic [ADDR_W-1:0] pc_vector,
	input wire logic [SRC_N-1:0] src_taken,
	input wire logic nmi_taken,
	input wire logic [ACT_W-1:0] active_levels
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire logic taken = (|src_taken) || nmi_taken;

	chk_vec_stands: assert property (pc_load && !core_vec_ack |=> pc_load && $stable(pc_vector))
		else $error("vector changed before the core took it");
	chk_ack_clears: assert property (pc_load && core_vec_ack && ce |=> !pc_load)
		else $error("vector still offered after the ack");
	chk_one_taken: assert property ($onehot0({nmi_taken, src_taken}))
		else $error("two sources taken at once");
	chk_taken_cause: assert property (taken |-> $past(pc_load && core_vec_ack))
		else $error("source taken without an acked vector");
	chk_nmi_vector: assert property (nmi_taken |->
		$past(pc_vector) == (vectors_in_boot ? BOOT_SECTION_START + OSC_FAILURE_NMI_VECTOR : OSC_FAILURE_NMI_VECTOR))
		else $error("wrong oscillator failure vector");
	chk_nmi_level: assert property (nmi_taken |-> active_levels[ACT_NMI] && !$past(active_levels[ACT_NMI]))
		else $error("oscillator failure routine not marked active");
	// A new level must lie above every active one, so the level word more than doubles.
	chk_nest_up: assert property (taken |-> {1'h0, active_levels} > {$past(active_levels), 1'h0})
		else $error("routine started at a level not above the active ones");
	chk_reti_drops: assert property (core_reti && ce && (|active_levels) && !(pc_load && core_vec_ack)
		|=> active_levels < $past(active_levels))
		else $error("return did not clear the highest active level");
endmodule // mlic_ctrl_assertions

bind mlic_ctrl mlic_ctrl_assertions i_mlic_ctrl_assertions (.mclk(mclk), .nrst(nrst), .ce(ce),
	.vectors_in_boot(vectors_in_boot), .core_vec_ack(core_vec_ack), .core_reti(core_reti), .pc_load(pc_load),
	.pc_vector(pc_vector), .src_taken(src_taken), .nmi_taken(nmi_taken), .active_levels(active_levels));

/* File: verif/mlic_ctrl_tb.sv */
// Self-checking testbench of the multi-level interrupt controller.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module mlic_ctrl_tb
	import mlic_pkg::*;
;
	logic mclk = 1'h0;
	logic nrst = 1'h0;
	logic [SRC_N-1:0] irq_req = '0;
	logic [SRC_N-1:0][LVL_W-1:0] irq_level = '0;
	logic [SRC_N-1:0][OFS_W-1:0] irq_offset = {SRC_N{4'h2}};
	logic osc_fail = 1'h0;
	logic [3:0] en_bits = 4'hF;
	logic low_round_robin = 1'h0;
	logic vectors_in_boot = 1'h0;
	logic reset_vec_in_boot = 1'h0;
	logic core_reti = 1'h0;
	logic ce = 1'h1;
	logic [7:0] ack_wait = 8'h00;
	logic core_vec_ack, pc_load, nmi_taken;
	logic [ADDR_W-1:0] pc_vector;
	logic [SRC_N-1:0] src_taken;
	logic [ACT_W-1:0] active_levels;
	int cmp_count = 0;
	int n_mismatch = 0;

	always #5 mclk = ~mclk;

	mlic_ctrl i_mlic_ctrl (.mclk(mclk), .nrst(nrst), .ce(ce), .irq_req(irq_req), .irq_level(irq_level),
		.irq_offset(irq_offset), .osc_fail(osc_fail), .global_irq_en(en_bits[3]), .high_en(en_bits[2]),
		.med_en(en_bits[1]), .low_en(en_bits[0]), .low_round_robin(low_round_robin),
		.vectors_in_boot(vectors_in_boot), .reset_vec_in_boot(reset_vec_in_boot), .core_vec_ack(core_vec_ack),
		.core_reti(core_reti), .pc_load(pc_load), .pc_vector(pc_vector), .src_taken(src_taken),
		.nmi_taken(nmi_taken), .active_levels(active_levels));
	mlic_core_model i_mlic_core_model (.mclk(mclk), .nrst(nrst), .pc_load(pc_load), .ack_wait(ack_wait),
		.core_vec_ack(core_vec_ack));

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic tick(inout int n);
		@(posedge mclk);
		#1;
		n++;
		if (n > 60) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	task automatic present(input logic [ADDR_W-1:0] v);
		int n;
		n = 0;
		while (pc_load !== 1'h1) tick(n);
		`CHK(pc_vector, v)
	endtask

	// Serves one vector; keep leaves the request up to test rotation.
	task automatic serve(input logic [ADDR_W-1:0] v, input logic [SRC_N-1:0] s, input logic nmi, input logic keep);
		int n;
		present(v);
		n = 0;
		while ({nmi_taken, src_taken} === '0) tick(n);
		`CHK({nmi_taken, src_taken}, {nmi, s})
		@(posedge mclk);
		if (!keep) irq_req <= irq_req & ~s;
	endtask

	task automatic quiet();
		repeat (6) begin
			@(posedge mclk);
			#1;
			`CHK(pc_load, 1'h0)
		end
		@(posedge mclk);
	endtask

	task automatic ret();
		@(posedge mclk);
		core_reti <= 1'h1;
		@(posedge mclk);
		core_reti <= 1'h0;
	endtask

	task automatic do_reset(input logic boot);
		@(posedge mclk);
		nrst <= 1'h0;
		reset_vec_in_boot <= boot;
		repeat (5) @(posedge mclk);
		#1;
		`CHK({pc_load, src_taken, nmi_taken, active_levels}, '0)
		@(posedge mclk);
		nrst <= 1'h1;
		present(boot ? BOOT_SECTION_START : RESET_VECTOR);
		repeat (4) @(posedge mclk);
	endtask

	task automatic t_vectors();
		logic [ADDR_W-1:0] exp;
		for (int i = 0; i < SRC_N; i++) begin
			@(posedge mclk);
			vectors_in_boot <= (i == 5);
			irq_level[i] <= LVL_HIGH;
			irq_req[i] <= 1'h1;
			exp = VECTOR_BASE[i] + (SINGLE_VECTOR_MASK[i] ? 16'h0000 : 16'h0002) + ((i == 5) ? BOOT_SECTION_START : 16'h0000);
			serve(exp, 12'h001 << i, 1'h0, 1'h0);
			ret();
		end
		vectors_in_boot <= 1'h0;
	endtask

	// The failure edge sets the pending flag at the next clock, so it is raised one cycle before the requests.
	task automatic t_priority();
		@(posedge mclk);
		osc_fail <= 1'h1;
		@(posedge mclk);
		irq_level[2:0] <= {LVL_HIGH, LVL_MED, LVL_LOW};
		irq_req[2:0] <= 3'h7;
		serve(16'h0002, 12'h000, 1'h1, 1'h0);
		ret();
		serve(16'h000E, 12'h004, 1'h0, 1'h0);
		ret();
		serve(16'h000A, 12'h002, 1'h0, 1'h0);
		ret();
		serve(16'h0006, 12'h001, 1'h0, 1'h0);
		ret();
		osc_fail <= 1'h0;
	endtask

	task automatic t_nesting();
		@(posedge mclk);
		irq_level[5:3] <= {LVL_MED, LVL_LOW, LVL_LOW};
		irq_level[8] <= LVL_HIGH;
		irq_req[3] <= 1'h1;
		serve(16'h0016, 12'h008, 1'h0, 1'h0);
		@(posedge mclk);
		irq_req[4] <= 1'h1;
		quiet();
		irq_req[5] <= 1'h1;
		serve(16'h002A, 12'h020, 1'h0, 1'h0);
		@(posedge mclk);
		irq_req[8] <= 1'h1;
		serve(16'h0042, 12'h100, 1'h0, 1'h0);
		ret();
		ret();
		ret();
		serve(16'h001E, 12'h010, 1'h0, 1'h0);
		ret();
	endtask

	task automatic t_round_robin(input logic rr);
		@(posedge mclk);
		low_round_robin <= rr;
		irq_level[1:0] <= {LVL_LOW, LVL_LOW};
		irq_req[1:0] <= 2'h3;
		serve(16'h0006, 12'h001, 1'h0, 1'h1);
		ret();
		serve(rr ? 16'h000A : 16'h0006, rr ? 12'h002 : 12'h001, 1'h0, 1'h0);
		ret();
		serve(rr ? 16'h0006 : 16'h000A, rr ? 12'h001 : 12'h002, 1'h0, 1'h0);
		ret();
	endtask

	// A frozen clock enable must hold back a pending request.
	task automatic t_freeze();
		@(posedge mclk);
		ce <= 1'h0;
		irq_level[10] <= LVL_LOW;
		irq_req[10] <= 1'h1;
		quiet();
		ce <= 1'h1;
		serve(TIMER_E_FOUR_CHAN_VECTOR_BASE + 16'h0002, 12'h400, 1'h0, 1'h0);
		ret();
	endtask

	task automatic t_enables();
		@(posedge mclk);
		ack_wait <= 8'h05;
		irq_level[9] <= LVL_OFF;
		irq_req[9] <= 1'h1;
		quiet();
		irq_level[9] <= LVL_MED;
		en_bits <= 4'hD;
		quiet();
		en_bits <= 4'h7;
		quiet();
		en_bits <= 4'hF;
		serve(16'h0050, 12'h200, 1'h0, 1'h0);
		ret();
		ack_wait <= 8'h00;
	endtask

	initial begin
		do_reset(1'h0);
		t_vectors();
		t_priority();
		t_nesting();
		t_round_robin(1'h1);
		t_round_robin(1'h0);
		t_freeze();
		t_enables();
		do_reset(1'h1);
		give_verdict();
	end
endmodule // mlic_ctrl_tb
